// ==== design/gpc_consts.svh ====
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
// Register offsets (word address on the plain port)
`define GPC_OFS_CFG       16'h781D
`define GPC_OFS_IRQ_STAT  16'h7820
`define GPC_OFS_IRQ_MASK  16'h7821
`define GPC_OFS_PIN_OUT   16'h7822
`define GPC_OFS_PIN_STAT  16'h7823
// Field positions of the configuration word
`define GPC_DIR_BIT       15
`define GPC_PULL_HI       14
`define GPC_PULL_LO       13
`define GPC_IRQ_MODE_BIT  12
`define GPC_DOM_BIT       11
`define GPC_POL_BIT       10
`define GPC_OD_BIT        9
`define GPC_ENA_BIT       8
`define GPC_FN_HI         7
`define GPC_FN_LO         4
`define GPC_LED1_HI       3
`define GPC_LED1_LO       2
`define GPC_LED2_HI       1
`define GPC_LED2_LO       0
// Reset value: input, pull-down, rising edge, first supply, active high,
// push-pull, tri-stated, function 0, both LEDs manual
`define GPC_CFG_RESET     16'hA40F
// Interrupt status bits
`define GPC_IRQ_PIN_BIT   0
`define GPC_IRQ_LOAD_BIT  1
`define GPC_IRQ_ERR_BIT   2
// Debounce times in microseconds and cycles at 200 MHz
`define GPC_CLK_MHZ       200
`define GPC_DEB_SHORT_US  1
`define GPC_DEB_LONG_US   100
`define GPC_DEB_SHORT_CYC (`GPC_DEB_SHORT_US * `GPC_CLK_MHZ)
`define GPC_DEB_LONG_CYC  (`GPC_DEB_LONG_US * `GPC_CLK_MHZ)
`endif

// ==== design/gpc_pkg.sv ====
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_PULL_NONE = 2'b00,
    GPC_PULL_DOWN = 2'b01,
    GPC_PULL_UP   = 2'b10,
    GPC_PULL_RSVD = 2'b11
  } gpc_pull_e;
  typedef enum logic [1:0] {
    GPC_LED_OFF   = 2'b00,
    GPC_LED_PSTAT = 2'b01,
    GPC_LED_RSVD  = 2'b10,
    GPC_LED_MAN   = 2'b11
  } gpc_led_e;
  typedef enum logic [1:0] {
    GPC_LD_IDLE = 2'b00,
    GPC_LD_REQ  = 2'b01,
    GPC_LD_WAIT = 2'b10,
    GPC_LD_DONE = 2'b11
  } gpc_load_e;
  // Configuration word as stored
  typedef struct packed {
    logic       pin_direction_select;
    gpc_pull_e  pin_pull_select;
    logic       pin_irq_edge_mode;
    logic       pin_supply_domain_select;
    logic       pin_polarity_select;
    logic       pin_open_drain_select;
    logic       pin_drive_enable;
    logic [3:0] pin_function_code;
    gpc_led_e   first_led_function;
    gpc_led_e   second_led_function;
  } gpc_cfg_s;
  // Input-side requests decoded from the pin
  typedef struct packed {
    logic gpio_in;
    logic pwr_onoff_req;
    logic sleep_wake_req;
    logic sleep_req;
    logic pwr_on_req;
    logic wdog_reset;
    logic [1:0] dvs_in;
    logic [1:0] hw_enable;
    logic [1:0] hw_control;
  } gpc_req_s;
  // Internal sources for output functions
  typedef struct packed {
    logic       clk_32k;
    logic       on_state;
    logic       sleep_state;
    logic       pwr_change;
    logic [1:0] dvs_done;
    logic [1:0] ext_pwr_en;
    logic       system_supply_good;
    logic       converter_power_good;
    logic       clk_2m;
    logic       aux_reset;
  } gpc_src_s;
  // Start-up memory read port
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } gpc_otp_s;
endpackage

// ==== design/gpc_debounce.sv ====
`include "gpc_consts.svh"
// Holds a new level only after it has stood stable for the chosen count
module gpc_debounce
  import gpc_pkg::*;
#(
  parameter int SHORT_CYC = `GPC_DEB_SHORT_CYC,
  parameter int LONG_CYC  = `GPC_DEB_LONG_CYC
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic raw_i,
  input  wire logic long_i,
  output logic      clean_o
);
  localparam int CW = $clog2(LONG_CYC + 1);
  logic [CW-1:0] cnt_ff;
  logic          clean_ff;
  logic [CW-1:0] limit;

  assign limit = long_i ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

  // Restart on any bounce; accept when the count reaches the limit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_ff   <= '0;
      clean_ff <= 1'b0;
    end else if (raw_i == clean_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff >= limit) begin
      cnt_ff   <= '0;
      clean_ff <= raw_i;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end
  assign clean_o = clean_ff;
endmodule

// ==== design/gpc_pin_cfg.sv ====
// Notes on behaviour
// - Two-bit pull select, default pull-down, 11 reserved
// - Mode 0: edge follows polarity setting
// - Mode 1: interrupt on both edges
// - Supply domain bit, default digital buffer supply
// - Polarity 1 active high, 0 inverted
// - Driver bit: 0 push-pull, 1 open-drain
// - Enable 0 keeps pin tri-stated
// - Input codes 0 to 7 decoded
// - Input codes 8 to 15 decoded
// - Output codes 0 to 4; 5-7 reserved
// - Output codes 8 to 15 decoded
// - First LED source, default manual
// - First LED shows load completed
// - Second LED source, default manual
// - Second LED shows load failed
`include "gpc_consts.svh"
module gpc_pin_cfg
  import gpc_pkg::*;
#(
  parameter int SHORT_CYC = `GPC_DEB_SHORT_CYC,
  parameter int LONG_CYC  = `GPC_DEB_LONG_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  output logic             otp_rd_o,
  input  wire gpc_otp_s    otp_i,
  output logic             busy_o,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_o,
  output logic             pull_up_o,
  output logic             pull_down_o,
  output logic             alt_supply_o,
  input  wire gpc_src_s    src_i,
  output gpc_req_s         req_o,
  input  wire logic        led_pstat_i,
  input  wire logic [1:0]  led_manual_i,
  output logic             first_led_o,
  output logic             second_led_o,
  output logic             irq_o
);
  gpc_cfg_s   cfg_ff;
  gpc_load_e  ld_ff;
  gpc_load_e  nxt_ld;
  logic       load_ok_ff;
  logic       load_err_ff;
  logic       gpio_out_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [15:0] rdata_ff;
  logic       pin_clean;
  logic       prev_ff;
  logic       level;
  logic       prev_level;
  logic       edge_hit;
  logic       long_deb;
  logic       out_val;
  logic       drive;
  logic [2:0] ev;
  logic       sw_ready;
  gpc_req_s   req_ff;
  logic       first_led_ff;
  logic       second_led_ff;

  assign sw_ready = (ld_ff == GPC_LD_DONE);
  assign busy_o   = ~sw_ready;

  // Start-up load sequence; software writes are held off until it is done
  always_comb begin
    nxt_ld = ld_ff;
    unique case (ld_ff)
      GPC_LD_IDLE: nxt_ld = GPC_LD_REQ;
      GPC_LD_REQ:  nxt_ld = GPC_LD_WAIT;
      GPC_LD_WAIT: if (otp_i.valid) nxt_ld = GPC_LD_DONE;
      GPC_LD_DONE: nxt_ld = GPC_LD_DONE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) ld_ff <= GPC_LD_IDLE;
    else ld_ff <= nxt_ld;
  end
  assign otp_rd_o = (ld_ff == GPC_LD_REQ);

  // Configuration word: loaded from memory unless it reports an error, then software writable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_ff <= gpc_cfg_s'(`GPC_CFG_RESET);
    end else if (ld_ff == GPC_LD_WAIT && otp_i.valid && !otp_i.error) begin
      cfg_ff <= gpc_cfg_s'(otp_i.data);
    end else if (sw_ready && wr_i && addr_i == `GPC_OFS_CFG) begin
      cfg_ff <= gpc_cfg_s'(wdata_i);
    end
  end

  // Load result flags drive the LED indications
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_ok_ff  <= 1'b0;
      load_err_ff <= 1'b0;
    end else if (ld_ff == GPC_LD_WAIT && otp_i.valid) begin
      load_ok_ff  <= ~otp_i.error;
      load_err_ff <= otp_i.error;
    end
  end

  // Software output level for code 0
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) gpio_out_ff <= 1'b0;
    else if (sw_ready && wr_i && addr_i == `GPC_OFS_PIN_OUT) gpio_out_ff <= wdata_i[0];
  end

  // Filter the pin; long filter for codes 0, 4, 14 and 15
  assign long_deb = cfg_ff.pin_function_code inside {4'h0, 4'h4, 4'hE, 4'hF};
  gpc_debounce #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_deb (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (pin_i),
    .long_i    (long_deb),
    .clean_o   (pin_clean)
  );

  // Logical level after polarity
  assign level      = cfg_ff.pin_polarity_select ? pin_clean : ~pin_clean;
  assign prev_level = cfg_ff.pin_polarity_select ? prev_ff : ~prev_ff;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) prev_ff <= 1'b0;
    else prev_ff <= pin_clean;
  end
  // Inverted polarity turns a falling pin into a rising logical level
  assign edge_hit = cfg_ff.pin_irq_edge_mode ? (pin_clean != prev_ff)
                                             : (level && !prev_level);

  // Requests decoded from the input function code
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_ff <= '0;
    end else begin
      req_ff <= '0;
      if (cfg_ff.pin_direction_select && cfg_ff.pin_drive_enable) begin
        unique case (cfg_ff.pin_function_code)
          4'h0, 4'h1: req_ff.gpio_in        <= level;
          4'h2:       req_ff.pwr_onoff_req  <= level;
          4'h3, 4'h4: req_ff.sleep_wake_req <= level;
          4'h5:       req_ff.sleep_req      <= level;
          4'h6:       req_ff.pwr_on_req     <= level;
          4'h7:       req_ff.wdog_reset     <= level;
          4'h8:       req_ff.dvs_in[0]      <= level;
          4'h9:       req_ff.dvs_in[1]      <= level;
          4'hA:       req_ff.hw_enable[0]   <= level;
          4'hB:       req_ff.hw_enable[1]   <= level;
          4'hC, 4'hE: req_ff.hw_control[0]  <= level;
          4'hD, 4'hF: req_ff.hw_control[1]  <= level;
        endcase
      end
    end
  end
  assign req_o = req_ff;

  // Output function select; reserved codes give a low level
  always_comb begin
    out_val = 1'b0;
    unique case (cfg_ff.pin_function_code)
      4'h0: out_val = gpio_out_ff;
      4'h1: out_val = src_i.clk_32k;
      4'h2: out_val = src_i.on_state;
      4'h3: out_val = src_i.sleep_state;
      4'h4: out_val = src_i.pwr_change;
      4'h5, 4'h6, 4'h7: out_val = 1'b0;
      4'h8: out_val = src_i.dvs_done[0];
      4'h9: out_val = src_i.dvs_done[1];
      4'hA: out_val = src_i.ext_pwr_en[0];
      4'hB: out_val = src_i.ext_pwr_en[1];
      4'hC: out_val = src_i.system_supply_good;
      4'hD: out_val = src_i.converter_power_good;
      4'hE: out_val = src_i.clk_2m;
      4'hF: out_val = src_i.aux_reset;
    endcase
  end

  // Pin driver: polarity, open-drain and tri-state control
  assign drive = cfg_ff.pin_polarity_select ? out_val : ~out_val;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (!cfg_ff.pin_drive_enable || cfg_ff.pin_direction_select) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (cfg_ff.pin_open_drain_select) begin
      pin_o    <= 1'b0;
      pin_oe_o <= ~drive;
    end else begin
      pin_o    <= drive;
      pin_oe_o <= 1'b1;
    end
  end

  // Pull and supply controls; reserved pull code turns both off
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pull_up_o    <= 1'b0;
      pull_down_o  <= 1'b0;
      alt_supply_o <= 1'b0;
    end else begin
      pull_up_o    <= (cfg_ff.pin_pull_select == GPC_PULL_UP);
      pull_down_o  <= (cfg_ff.pin_pull_select == GPC_PULL_DOWN);
      alt_supply_o <= cfg_ff.pin_supply_domain_select;
    end
  end

  // LEDs: selected source, overridden by load result indication
  function automatic logic led_sel(gpc_led_e f, logic man);
    logic r;
    r = 1'b0;
    unique case (f)
      GPC_LED_OFF:   r = 1'b0;
      GPC_LED_PSTAT: r = led_pstat_i;
      GPC_LED_RSVD:  r = 1'b0;
      GPC_LED_MAN:   r = man;
    endcase
    return r;
  endfunction
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      first_led_ff  <= 1'b0;
      second_led_ff <= 1'b0;
    end else begin
      first_led_ff  <= led_sel(cfg_ff.first_led_function, led_manual_i[0])
                       | load_ok_ff;
      second_led_ff <= led_sel(cfg_ff.second_led_function, led_manual_i[1])
                       | load_err_ff;
    end
  end
  assign first_led_o  = first_led_ff;
  assign second_led_o = second_led_ff;

  // Sticky interrupt status; a new event wins over a clear
  assign ev[`GPC_IRQ_PIN_BIT]  = edge_hit && cfg_ff.pin_direction_select
                                 && cfg_ff.pin_drive_enable;
  assign ev[`GPC_IRQ_LOAD_BIT] = (ld_ff == GPC_LD_WAIT) && otp_i.valid && !otp_i.error;
  assign ev[`GPC_IRQ_ERR_BIT]  = (ld_ff == GPC_LD_WAIT) && otp_i.valid && otp_i.error;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat_ff <= 3'h0;
    end else if (sw_ready && wr_i && addr_i == `GPC_OFS_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~wdata_i[2:0]) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) irq_mask_ff <= 3'h0;
    else if (sw_ready && wr_i && addr_i == `GPC_OFS_IRQ_MASK) irq_mask_ff <= wdata_i[2:0];
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `GPC_OFS_CFG:      rdata_ff <= cfg_ff;
        `GPC_OFS_IRQ_STAT: rdata_ff <= {13'h0000, irq_stat_ff};
        `GPC_OFS_IRQ_MASK: rdata_ff <= {13'h0000, irq_mask_ff};
        `GPC_OFS_PIN_OUT:  rdata_ff <= {15'h0000, gpio_out_ff};
        `GPC_OFS_PIN_STAT: rdata_ff <= {13'h0000, busy_o, pin_clean, level};
        default:           rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign rdata_o = rdata_ff;

  // Pin interrupt follows the edge rule within one cycle
  pin_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ev[0] && !cfg_ff.pin_irq_edge_mode) |-> level && !prev_level)
    else $error("pin interrupt without matching edge");
  both_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.pin_direction_select && cfg_ff.pin_drive_enable && cfg_ff.pin_irq_edge_mode
     && pin_clean != prev_ff) |=> irq_stat_ff[0])
    else $error("edge missed in both-edge mode");
  tri_state_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(cfg_ff.pin_drive_enable) |-> !pin_oe_o)
    else $error("pin driven while disabled");
  open_drain_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(cfg_ff.pin_open_drain_select) |-> !pin_o)
    else $error("open drain drove high");
  pull_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(pull_up_o && pull_down_o))
    else $error("both pulls on");
  supply_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alt_supply_o == $past(cfg_ff.pin_supply_domain_select))
    else $error("supply select mismatch");
  led_done_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    load_ok_ff |=> first_led_o)
    else $error("first LED missed load done");
  led_err_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    load_err_ff |=> second_led_o)
    else $error("second LED missed load error");
  sequence load_seq;
    (ld_ff == GPC_LD_REQ) ##1 (ld_ff == GPC_LD_WAIT);
  endsequence
  load_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(otp_rd_o) |-> load_seq)
    else $error("load sequence broken");
  out_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.pin_function_code inside {4'h5, 4'h6, 4'h7}) |-> !out_val)
    else $error("reserved code drives high");
  // Pull controls follow the code one cycle later, never both at once
  pull_down_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.pin_pull_select == GPC_PULL_DOWN) |=> pull_down_o && !pull_up_o)
    else $error("pull-down not applied");
  pull_up_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.pin_pull_select == GPC_PULL_UP) |=> pull_up_o && !pull_down_o)
    else $error("pull-up not applied");
  // Push-pull output path; checked against the source, not the driver net
  logic cmos_out;
  assign cmos_out = !cfg_ff.pin_direction_select && cfg_ff.pin_drive_enable
                    && !cfg_ff.pin_open_drain_select;
  push_pull_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmos_out |=> pin_oe_o)
    else $error("push-pull pin not driven");
  pol_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cmos_out && cfg_ff.pin_polarity_select) |=> pin_o == $past(out_val))
    else $error("active-high output level wrong");
  pol_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cmos_out && !cfg_ff.pin_polarity_select) |=> pin_o == !$past(out_val))
    else $error("inverted output level wrong");
  gpio_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cmos_out && cfg_ff.pin_polarity_select && cfg_ff.pin_function_code == 4'h0)
    |=> pin_o == $past(gpio_out_ff))
    else $error("software level not on pin");
  supply_good_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cmos_out && cfg_ff.pin_polarity_select && cfg_ff.pin_function_code == 4'hC)
    |=> pin_o == $past(src_i.system_supply_good))
    else $error("supply good not on pin");
  // Input requests track the logical level one cycle later
  logic input_on;
  assign input_on = cfg_ff.pin_direction_select && cfg_ff.pin_drive_enable;
  gpio_in_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (input_on && cfg_ff.pin_function_code == 4'h1) |=> req_o.gpio_in == $past(level))
    else $error("input level not forwarded");
  hw_ctrl_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (input_on && cfg_ff.pin_function_code == 4'hE) |=> req_o.hw_control[0] == $past(level))
    else $error("control request not forwarded");
  // LEDs stay dark when switched off, unless a load result holds them lit
  led1_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.first_led_function == GPC_LED_OFF && !load_ok_ff) |=> !first_led_o)
    else $error("first LED lit while off");
  led2_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_ff.second_led_function == GPC_LED_OFF && !load_err_ff) |=> !second_led_o)
    else $error("second LED lit while off");
endmodule

// ==== dv/gpc_otp_model.sv ====
// Start-up memory: answers each read request after lat_i cycles
module gpc_otp_model
  import gpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  lat_i,
  input  wire logic [15:0] word_i,
  input  wire logic        err_i,
  output gpc_otp_s         otp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;

  // Data toggles outside the valid pulse so a stale capture shows up
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 8'h00;
      otp_o  <= '{valid: 1'b0, error: 1'b0, data: 16'hA5A5};
    end else begin
      otp_o.valid <= 1'b0;
      otp_o.error <= 1'b0;
      otp_o.data  <= ~otp_o.data;
      if (rd_i) begin
        cnt_ff <= lat_i;
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          otp_o <= '{valid: 1'b1, error: err_i, data: word_i};
        end
      end
    end
  end
endmodule

// ==== dv/gpc_pin_cfg_bench.sv ====
`include "gpc_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module gpc_pin_cfg_bench
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LG = 4;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic        otp_rd_o, busy_o, pin_o, pin_oe_o, pull_up_o, pull_down_o;
  logic        alt_supply_o, first_led_o, second_led_o, irq_o;
  gpc_otp_s    otp_i;
  gpc_src_s    src_i = '0;
  gpc_req_s    req_o;
  logic        led_pstat_i = 1'b0;
  logic [1:0]  led_manual_i = 2'b00;
  logic        ext_lvl = 1'b0;
  logic        err = 1'b0;
  logic [7:0]  lat = 8'h0C;
  logic [15:0] good, lvl, exp_v;
  logic [15:0] exp_q[$];
  logic        rd_seen = 1'b0;
  logic        d;
  int          n_errors = 0;
  int          n_tests = 0;
  // Pin wire: the block wins while it drives, else the outside level
  wire         pin_i = pin_oe_o ? pin_o : ext_lvl;

  gpc_pin_cfg #(.SHORT_CYC(2), .LONG_CYC(LG)) gpc_pin_cfg_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .otp_rd_o(otp_rd_o),
    .otp_i(otp_i), .busy_o(busy_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
    .alt_supply_o(alt_supply_o), .src_i(src_i), .req_o(req_o),
    .led_pstat_i(led_pstat_i), .led_manual_i(led_manual_i),
    .first_led_o(first_led_o), .second_led_o(second_led_o), .irq_o(irq_o));

  gpc_otp_model gpc_otp_model_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_i(otp_rd_o), .lat_i(lat),
    .word_i(good), .err_i(err), .otp_o(otp_i));

  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [15:0] mk(logic dr, logic [1:0] p, logic m, logic s, logic o,
      logic od, logic e, logic [3:0] f, logic [1:0] l1 = 2'b11, logic [1:0] l2 = 2'b11);
    return {dr, p, m, s, o, od, e, f, l1, l2};
  endfunction

  function automatic logic exp_out(int c, logic v);
    case (c)
      0: return v;
      1: return src_i.clk_32k;
      2: return src_i.on_state;
      3: return src_i.sleep_state;
      4: return src_i.pwr_change;
      8, 9: return src_i.dvs_done[c-8];
      10, 11: return src_i.ext_pwr_en[c-10];
      12: return src_i.system_supply_good;
      13: return src_i.converter_power_good;
      14: return src_i.clk_2m;
      15: return src_i.aux_reset;
      default: return 1'b0;
    endcase
  endfunction

  function automatic gpc_req_s exp_req(int c);
    gpc_req_s r;
    r = '0;
    case (c)
      0, 1: r.gpio_in = 1'b1;
      2: r.pwr_onoff_req = 1'b1;
      3, 4: r.sleep_wake_req = 1'b1;
      5: r.sleep_req = 1'b1;
      6: r.pwr_on_req = 1'b1;
      7: r.wdog_reset = 1'b1;
      8, 9: r.dvs_in[c-8] = 1'b1;
      10, 11: r.hw_enable[c-10] = 1'b1;
      12, 14: r.hw_control[0] = 1'b1;
      default: r.hw_control[1] = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic exp_led(int l, logic p, logic m);
    return (l == 1) ? p : ((l == 3) ? m : 1'b0);
  endfunction

  task automatic settle(int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(logic [15:0] a, logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(v);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // Outside level changes at an edge, then waits out the long debounce
  task automatic pin_lvl(logic v);
    @(posedge clk_i);
    ext_lvl <= v;
    settle(LG + 6);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 60 && busy_o !== 1'b0; i++) @(posedge clk_i);
    `CHK(busy_o, 1'b0)
  endtask

  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_seen) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_o, exp_v)
    end
    rd_seen <= rd_i;
  end

  // Whole run needs under a thousand cycles
  initial begin
    settle(20000);
    n_errors++;
    results();
  end

  initial begin
    void'($urandom(32'hdc7e));
    good = 16'($urandom);
    if (good[14:13] == 2'b11) good[14:13] = 2'b01;
    settle(2);
    sys_rst_i <= 1'b0;
    rd(`GPC_OFS_CFG, 16'hA40F); // defaults
    wr(`GPC_OFS_CFG, 16'h0000);
    rd(`GPC_OFS_CFG, 16'hA40F); // write while loading ignored
    wait_ready();
    rd(`GPC_OFS_CFG, good); // loaded word
    rd(`GPC_OFS_IRQ_STAT, 16'h0002);
    rd(16'h1234, 16'h0000);
    `CHK(first_led_o, 1'b1) // load done
    wr(`GPC_OFS_IRQ_MASK, 16'h0002);
    settle(1);
    `CHK(irq_o, 1'b1)
    wr(`GPC_OFS_IRQ_STAT, 16'h0007);
    settle(1);
    `CHK(irq_o, 1'b0)
    for (int p = 0; p < 4; p++) begin
      wr(`GPC_OFS_CFG, mk(1'b1, p[1:0], 1'b0, p[0], 1'b1, 1'b0, 1'b0, 4'h1));
      settle(2);
      `CHK({pull_up_o, pull_down_o}, (p == 1) ? 2'b01 : ((p == 2) ? 2'b10 : 2'b00))
      `CHK(alt_supply_o, p[0]) // supply
      `CHK(pin_oe_o, 1'b0) // floating
    end
    for (int c = 0; c < 16; c++) begin
      src_i <= gpc_src_s'(12'($urandom));
      lvl = 16'($urandom);
      wr(`GPC_OFS_PIN_OUT, lvl);
      wr(`GPC_OFS_CFG, mk(1'b0, 2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      settle(2);
      `CHK(pin_o, exp_out(c, lvl[0])) // output mux
      `CHK(pin_oe_o, 1'b1) // driving
      rd(`GPC_OFS_PIN_OUT, {15'h0000, lvl[0]});
    end
    for (int k = 0; k < 8; k++) begin
      wr(`GPC_OFS_PIN_OUT, {15'h0000, k[0]});
      wr(`GPC_OFS_CFG, mk(1'b0, 2'b00, 1'b0, 1'b0, k[1], k[2], 1'b1, 4'h0));
      settle(2);
      d = k[0] ^ ~k[1];
      `CHK(pin_oe_o, k[2] ? ~d : 1'b1) // driver kind
      `CHK(pin_o, k[2] ? 1'b0 : d) // polarity
    end
    for (int c = 0; c < 16; c++) begin
      wr(`GPC_OFS_CFG, mk(1'b1, 2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      pin_lvl(1'b1);
      `CHK(req_o, exp_req(c)) // input decode
      pin_lvl(1'b0);
      `CHK(req_o, gpc_req_s'(12'h000)) // released
    end
    wr(`GPC_OFS_IRQ_MASK, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(`GPC_OFS_CFG, mk(1'b1, 2'b00, k[1], 1'b0, k[0], 1'b0, 1'b1, 4'h1));
      settle(10);
      wr(`GPC_OFS_IRQ_STAT, 16'h0007);
      pin_lvl(1'b1);
      `CHK(irq_o, k[1] | k[0]) // rising edge
      rd(`GPC_OFS_IRQ_STAT, {15'h0000, k[1] | k[0]});
      rd(`GPC_OFS_PIN_STAT, {13'h0000, 1'b0, 1'b1, k[0]});
      wr(`GPC_OFS_IRQ_STAT, 16'h0007);
      pin_lvl(1'b0);
      rd(`GPC_OFS_IRQ_STAT, {15'h0000, k[1] | ~k[0]}); // falling edge
    end
    for (int l = 0; l < 4; l++) begin
      led_pstat_i <= 1'($urandom);
      led_manual_i <= 2'($urandom);
      wr(`GPC_OFS_CFG, mk(1'b1, 2'b01, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 2'b11, l[1:0]));
      settle(2);
      `CHK(second_led_o, exp_led(l, led_pstat_i, led_manual_i[1]))
    end
    // Second start-up with a failing memory and a prompt answer
    err <= 1'b1;
    lat <= 8'h01;
    sys_rst_i <= 1'b1;
    settle(2);
    sys_rst_i <= 1'b0;
    wait_ready();
    rd(`GPC_OFS_CFG, 16'hA40F); // reset value kept
    rd(`GPC_OFS_IRQ_STAT, 16'h0004);
    `CHK(second_led_o, 1'b1) // load failed
    for (int l = 0; l < 4; l++) begin
      led_pstat_i <= 1'($urandom);
      led_manual_i <= 2'($urandom);
      wr(`GPC_OFS_CFG, mk(1'b1, 2'b01, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, l[1:0], 2'b00));
      settle(2);
      `CHK(first_led_o, exp_led(l, led_pstat_i, led_manual_i[0]))
    end
    settle(2);
    results();
  end
endmodule
